// ==== data_move_instruction_exec.sv ====
`timescale 1ns/1ns
// Contract
// - File-to-file move copies source byte to destination; flags untouched.
// - Source address may be any of 000h to FFFh, bank ignored.
// - Destination address is the full 12 bits of the second word.
// - Accumulator may be source or destination via its data address.
// - Program counter low and top-of-stack bytes are refused as destinations.
// - First word 1100+source, second word 1111+destination.
// - Two cycles: read source first, write destination second, no dummy read.
// - Bank select upper four bits stay zero after literal-to-bank load.
module data_move_instruction_exec (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Instruction fetch
    input wire logic [15:0] instr_i,
    input wire logic instr_valid_i,
    // Data memory
    input wire logic [7:0] mem_rdata_i,
    output move_exec_pkg::mem_req_t mem_req_o,
    // Status
    output logic [3:0] bank_select_register_o,
    output logic busy_o,
    output logic dest_refused_o,
    output logic [1:0] phase_o
);

    typedef struct packed {
        move_exec_pkg::exec_state_t st;
        logic [7:0] data;
        logic [3:0] bank;
        move_exec_pkg::mem_req_t req;
        logic busy;
        logic refused;
        logic [1:0] ph;
        logic lit_pend;
        logic [3:0] lit;
    } state_t;

    state_t s;
    state_t next_s;
    logic [1:0] phase;
    logic last;

    // Free-running quarter counter; the fetch unit presents words in step with it
    phase_counter u_phase (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .phase_o(phase),
        .last_o(last)
    );

    // Word decoders shared by the states that look at the fetch port
    function automatic logic is_move_source(input logic [15:0] w);
        is_move_source = (w[15:12] == move_exec_pkg::OP_FF_SRC);
    endfunction : is_move_source

    function automatic logic is_move_dest(input logic [15:0] w);
        is_move_dest = (w[15:12] == move_exec_pkg::OP_FF_DST);
    endfunction : is_move_dest

    function automatic logic is_lit_bank(input logic [15:0] w);
        is_lit_bank = (w[15:8] == move_exec_pkg::OP_LIT_BANK);
    endfunction : is_lit_bank

    // Writes here would break program flow, so they are dropped
    function automatic logic dest_forbidden(input logic [11:0] a);
        case (a)
            move_exec_pkg::ADDR_PROGRAM_COUNTER_LOW,
            move_exec_pkg::ADDR_TOP_OF_STACK_LOW,
            move_exec_pkg::ADDR_TOP_OF_STACK_HIGH,
            move_exec_pkg::ADDR_TOP_OF_STACK_UPPER:
            begin
                dest_forbidden = 1'b1;
            end
            default:
            begin
                dest_forbidden = 1'b0;
            end
        endcase
    endfunction : dest_forbidden

    // Read keeps the last write data so only the strobe and address move
    function automatic move_exec_pkg::mem_req_t read_req(input logic [11:0] a,
        input logic [7:0] d);
        read_req.re = 1'b1;
        read_req.we = 1'b0;
        read_req.addr = a;
        read_req.wdata = d;
    endfunction : read_req

    // Read strobe stays low in the write cycle: no dummy read
    function automatic move_exec_pkg::mem_req_t write_req(input logic [11:0] a,
        input logic [7:0] d);
        write_req.re = 1'b0;
        write_req.we = 1'b1;
        write_req.addr = a;
        write_req.wdata = d;
    endfunction : write_req

    // One reset image for the whole state
    function automatic state_t reset_state();
        reset_state = '0;
        reset_state.st = move_exec_pkg::ST_IDLE;
        reset_state.bank = move_exec_pkg::BANK_RESET;
        reset_state.ph = move_exec_pkg::PHASE_RESET;
    endfunction : reset_state

    // Decoded view of the fetch port
    logic at_q1;
    logic at_q3;
    logic src_word;
    logic dst_word;
    logic lit_word;

    assign at_q1 = (phase == move_exec_pkg::Q1);
    assign at_q3 = (phase == move_exec_pkg::Q3);
    assign src_word = instr_valid_i && is_move_source(instr_i);
    assign dst_word = instr_valid_i && is_move_dest(instr_i);
    assign lit_word = instr_valid_i && is_lit_bank(instr_i);

    always_comb
    begin
        next_s = s;
        next_s.req.re = 1'b0;
        next_s.req.we = 1'b0;
        next_s.ph = phase;
        case (s.st)
            move_exec_pkg::ST_IDLE:
            begin
                next_s.busy = 1'b0;
                // Instruction word is sampled at Q1 decode
                if (at_q1)
                begin
                    if (src_word)
                    begin
                        // Whole 12-bit address, no bank applied
                        next_s.req = read_req(instr_i[11:0], s.req.wdata);
                        next_s.busy = 1'b1;
                        next_s.lit_pend = 1'b0;
                        next_s.st = move_exec_pkg::ST_FF_WAIT;
                    end
                    // Latched at Q1 so a word that changes later cannot disturb the load
                    else if (lit_word)
                    begin
                        // Only the low nibble is held, so upper bank bits stay zero
                        next_s.lit = instr_i[3:0];
                        next_s.lit_pend = 1'b1;
                    end
                end
                // Bank written in the last quarter of the same cycle
                if (last && s.lit_pend)
                begin
                    next_s.bank = s.lit;
                    next_s.lit_pend = 1'b0;
                end
            end

            move_exec_pkg::ST_FF_WAIT:
            begin
                // Read data captured when the Q2 read returns
                if (at_q3)
                begin
                    next_s.data = mem_rdata_i;
                end
                if (last)
                begin
                    next_s.st = move_exec_pkg::ST_FF_WRITE;
                end
            end

            move_exec_pkg::ST_FF_WRITE:
            begin
                // Destination word checked at Q3 so the write lands at Q4
                if (at_q3 && dst_word)
                begin
                    if (dest_forbidden(instr_i[11:0]))
                    begin
                        next_s.refused = 1'b1;
                    end
                    else
                    begin
                        next_s.refused = 1'b0;
                        next_s.req = write_req(instr_i[11:0], s.data);
                    end
                end
                if (last)
                begin
                    next_s.busy = 1'b0;
                    next_s.st = move_exec_pkg::ST_IDLE;
                end
            end

            // Unused encoding falls back to idle
            default:
            begin
                next_s.st = move_exec_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s <= reset_state();
        end
        else
        begin
            s <= next_s;
        end
    end

    // Every output is a register field, with no logic after it
    assign mem_req_o = s.req;
    // Only four bits are stored, so the upper four can never be set
    assign bank_select_register_o = s.bank;
    assign busy_o = s.busy;
    assign dest_refused_o = s.refused;
    assign phase_o = s.ph;

endmodule : data_move_instruction_exec

// ==== move_exec_checker.sv ====
`timescale 1ns/1ns
module move_exec_checker (
    // Watched ports
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] mem_rdata_i,
    input wire move_exec_pkg::mem_req_t mem_req_o,
    input wire logic [3:0] bank_select_register_o,
    input wire logic busy_o,
    input wire logic [1:0] phase_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_we_pulse: assert property (mem_req_o.we |=> !mem_req_o.we)
        else $error("write strobe too long");
    a_re_pulse: assert property (mem_req_o.re |=> !mem_req_o.re)
        else $error("read strobe too long");
    a_we_no_read: assert property (mem_req_o.we |-> busy_o && !mem_req_o.re)
        else $error("write outside move or with read");
    a_re_in_move: assert property (mem_req_o.re |-> busy_o)
        else $error("read outside move");
    a_dest_allowed: assert property (mem_req_o.we |-> mem_req_o.addr < 12'hff9
        || mem_req_o.addr inside {12'hffa, 12'hffb, 12'hffc}) else $error("forbidden write");
    a_read_then_write: assert property (mem_req_o.we |-> $past(mem_req_o.re, 6))
        else $error("write not six clocks after read");
    a_byte_copied: assert property (mem_req_o.we
        |-> mem_req_o.wdata == $past(mem_rdata_i, 6))
        else $error("written byte differs from read byte");
    a_bank_at_q4: assert property ($changed(bank_select_register_o)
        |-> phase_o == move_exec_pkg::Q4) else $error("bank changed outside last quarter");
    a_bank_quiet: assert property ($changed(bank_select_register_o) |-> !busy_o)
        else $error("bank changed during move");
    c_write: cover property (mem_req_o.we);
    c_bank: cover property ($changed(bank_select_register_o));
    c_move_end: cover property (busy_o ##1 !busy_o);
endmodule : move_exec_checker

// ==== move_exec_pkg.sv ====
package move_exec_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;

    // Opcode fields
    localparam logic [3:0] OP_FF_SRC = 4'hc;
    localparam logic [3:0] OP_FF_DST = 4'hf;
    localparam logic [7:0] OP_LIT_BANK = 8'h01;

    // Quarter-phase numbering
    localparam logic [1:0] Q1 = 2'h0;
    localparam logic [1:0] Q2 = 2'h1;
    localparam logic [1:0] Q3 = 2'h2;
    localparam logic [1:0] Q4 = 2'h3;

    // Data-space addresses that cannot be move destinations
    localparam logic [11:0] ADDR_PROGRAM_COUNTER_LOW = 12'hff9;
    localparam logic [11:0] ADDR_TOP_OF_STACK_LOW = 12'hffd;
    localparam logic [11:0] ADDR_TOP_OF_STACK_HIGH = 12'hffe;
    localparam logic [11:0] ADDR_TOP_OF_STACK_UPPER = 12'hfff;

    // Reset values
    localparam logic [3:0] BANK_RESET = 4'h0;
    localparam logic [1:0] PHASE_RESET = 2'h0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FF_WAIT,
        ST_FF_WRITE
    } exec_state_t;

    typedef struct packed {
        logic re;
        logic we;
        logic [11:0] addr;
        logic [7:0] wdata;
    } mem_req_t;

endpackage : move_exec_pkg

// ==== phase_counter.sv ====
`timescale 1ns/1ns
module phase_counter (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Phase
    output logic [1:0] phase_o,
    output logic last_o
);

    logic [1:0] phase;
    logic [1:0] next_phase;

    always_comb
    begin
        next_phase = phase + 2'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            phase <= move_exec_pkg::PHASE_RESET;
        end
        else
        begin
            phase <= next_phase;
        end
    end

    assign phase_o = phase;
    assign last_o = (phase == move_exec_pkg::Q4);

endmodule : phase_counter

// ==== testbench.sv ====
`timescale 1ns/1ns
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] instr_i = 16'h0000;
    logic instr_valid_i = 1'b0;
    logic [7:0] mem_rdata_i = 8'h00;
    move_exec_pkg::mem_req_t mem_req_o;
    logic [3:0] bank_select_register_o;
    logic busy_o;
    logic dest_refused_o;
    logic [1:0] phase_o;
    logic [7:0] mem [4096];
    logic [19:0] expq [$];
    logic [31:0] seed = 32'h0fbefe0d;
    int fails = 0;
    int tests_run = 0;
    data_move_instruction_exec data_move_instruction_exec_i (.clk_i(clk_i), .rst_i(rst_i),
        .instr_i(instr_i), .instr_valid_i(instr_valid_i), .mem_rdata_i(mem_rdata_i),
        .mem_req_o(mem_req_o), .bank_select_register_o(bank_select_register_o),
        .busy_o(busy_o), .dest_refused_o(dest_refused_o), .phase_o(phase_o));
    initial forever #50 clk_i = ~clk_i;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    // One word held for a whole instruction cycle keeps phase alignment simple
    task automatic word(input logic [15:0] w);
        instr_i = w;
        instr_valid_i = 1'b1;
        repeat (4) @(posedge clk_i);
        #1;
        check({18'h0, phase_o}, {18'h0, move_exec_pkg::Q4});
    endtask : word
    task automatic move(input logic [11:0] src, input logic [11:0] dst, input logic gap);
        logic bad;
        bad = dst inside {12'hff9, 12'hffd, 12'hffe, 12'hfff};
        if (!bad)
            expq.push_back({dst, mem[src]});
        if (!bad)
            mem[dst] = mem[src];
        word({move_exec_pkg::OP_FF_SRC, src});
        word({move_exec_pkg::OP_FF_DST, dst});
        if (gap)
            word(16'h0000);
        if (gap)
            check({19'h0, dest_refused_o}, {19'h0, bad});
    endtask : move
    // Memory model answers after the edge so a fresh address is seen
    always @(posedge clk_i)
    begin
        if (mem_req_o.we === 1'b1)
            check({mem_req_o.addr, mem_req_o.wdata},
                expq.size() ? expq.pop_front() : 20'hfffff);
        #1 mem_rdata_i = mem[mem_req_o.addr];
    end
    initial
    begin
        logic [7:0] k;
        foreach (mem[i])
            mem[i] = 8'(rnd());
        repeat (2) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        move(12'h000, 12'hff8, 1'b1);
        move(12'hfff, 12'h000, 1'b1);
        move(12'h123, 12'hff9, 1'b1);
        move(12'h456, 12'hffd, 1'b1);
        move(12'h789, 12'hffe, 1'b1);
        move(12'habc, 12'hfff, 1'b1);
        move(12'hffb, 12'hffc, 1'b1);
        for (int i = 0; i < 12; i++)
        begin
            move(12'(rnd()), 12'(rnd()), 1'(i));
            k = 8'(rnd());
            word({move_exec_pkg::OP_LIT_BANK, k});
            check({16'h0, bank_select_register_o}, {16'h0, k[3:0]});
        end
        word(16'h0000);
        check(20'(expq.size()), 20'h0);
        test_done();
    end
    initial
    begin
        #1000000;
        fails++;
        test_done();
    end
endmodule : testbench
bind data_move_instruction_exec move_exec_checker move_exec_checker_i (.clk_i(clk_i),
    .rst_i(rst_i), .mem_rdata_i(mem_rdata_i), .mem_req_o(mem_req_o),
    .bank_select_register_o(bank_select_register_o), .busy_o(busy_o), .phase_o(phase_o));
